// [verilog/spel_top.sv]
// Purpose: enable latches, input select and loopback of a dual transceiver
// Assumes: all control pins asynchronous, reference clock is clk_sys
// Notes: latches are emulated by registers, one cycle plus sync late
`timescale 1ns/1ps
`include "spel_regs.svh"

module spel_top #(
    parameter int NUM_CH = 2
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic device_reset_n,
    input wire logic [3:0] shared_enable_bus,
    input wire logic driver_enable_latch_open,
    input wire logic rx_power_latch_open,
    input wire logic selftest_latch_open,
    input wire logic loopback_enable,
    input wire logic input_select_a,
    input wire logic input_select_b,
    input wire spel_pkg::spel_serial_in_type serial_in,
    input wire logic [1:0] tx_serial,
    output logic [1:0] cdr_in,
    output logic [3:0] serial_out_pair,
    output spel_pkg::spel_ctrl_type ctrl
);

    if (NUM_CH != 2) begin : g_bad_ch
        $error("spel_top serves exactly two channels");
    end

    // pick one bus bit through the fixed mapping table
    function automatic logic spel_pick(
        input logic [3:0] bus,
        input logic [1:0] idx
    );
        spel_pick = bus[idx];
    endfunction : spel_pick

    logic [14:0] sync1_q;
    logic [14:0] sync2_q;
    logic [14:0] pins;
    logic [3:0] bus_s;
    logic drv_open_s;
    logic rx_open_s;
    logic test_open_s;
    logic loop_s;
    logic [1:0] sel_s;
    logic [1:0] prim_s;
    logic [1:0] sec_s;
    logic devrst_s;
    logic [3:0] drv_q;
    logic [1:0] rx_q;
    logic [3:0] test_q;
    logic [3:0] drv_map;
    logic [1:0] rx_map;
    logic [3:0] test_map;
    logic [1:0] cdr_q;
    logic [3:0] out_q;

    assign pins = {shared_enable_bus, driver_enable_latch_open,
        rx_power_latch_open, selftest_latch_open, loopback_enable,
        input_select_b, input_select_a, serial_in.primary,
        serial_in.secondary, device_reset_n};

    // every pin except tx_serial is asynchronous, two flops before any use
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1_q <= `SPEL_SYNC_RESET;
            sync2_q <= `SPEL_SYNC_RESET;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    assign bus_s = sync2_q[14:11];
    assign drv_open_s = sync2_q[10];
    assign rx_open_s = sync2_q[9];
    assign test_open_s = sync2_q[8];
    assign loop_s = sync2_q[7];
    assign sel_s = sync2_q[6:5];
    assign prim_s = sync2_q[4:3];
    assign sec_s = sync2_q[2:1];
    assign devrst_s = ~sync2_q[0];

    // fixed routing of bus bits to each latch
    always_comb begin
        drv_map[0] = spel_pick(bus_s, `SPEL_MAP_DRV_A1);
        drv_map[1] = spel_pick(bus_s, `SPEL_MAP_DRV_A2);
        drv_map[2] = spel_pick(bus_s, `SPEL_MAP_DRV_B1);
        drv_map[3] = spel_pick(bus_s, `SPEL_MAP_DRV_B2);
        rx_map[0] = spel_pick(bus_s, `SPEL_MAP_RX_A);
        rx_map[1] = spel_pick(bus_s, `SPEL_MAP_RX_B);
        test_map[0] = spel_pick(bus_s, `SPEL_MAP_TEST_TX_A);
        test_map[1] = spel_pick(bus_s, `SPEL_MAP_TEST_RX_A);
        test_map[2] = spel_pick(bus_s, `SPEL_MAP_TEST_TX_B);
        test_map[3] = spel_pick(bus_s, `SPEL_MAP_TEST_RX_B);
    end

    // driver enable latch; device reset wins over an open latch
    always_ff @(posedge clk_sys) begin
        if (reset || devrst_s) begin
            drv_q <= `SPEL_DRV_RESET;
        end else if (drv_open_s) begin
            drv_q <= drv_map;
        end
    end

    // receive power latch
    always_ff @(posedge clk_sys) begin
        if (reset || devrst_s) begin
            rx_q <= `SPEL_RX_RESET;
        end else if (rx_open_s) begin
            rx_q <= rx_map;
        end
    end

    // self-test latch: device reset acts only while closed, open follows bus
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            test_q <= `SPEL_TEST_RESET;
        end else if (test_open_s) begin
            test_q <= test_map;
        end else if (devrst_s) begin
            test_q <= `SPEL_TEST_RESET;
        end
    end

    // receive input choice per channel
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            cdr_q <= 2'h0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (loop_s) begin
                    cdr_q[c] <= tx_serial[c];
                end else if (sel_s[c]) begin
                    cdr_q[c] <= prim_s[c];
                end else begin
                    cdr_q[c] <= sec_s[c];
                end
            end
        end
    end

    // drivers: a1,a2 carry channel a, b1,b2 carry channel b
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            out_q <= 4'h0;
        end else begin
            for (int d = 0; d < 4; d++) begin
                if (!drv_q[d]) begin
                    out_q[d] <= 1'b0;
                end else if (loop_s) begin
                    out_q[d] <= 1'b1;
                end else begin
                    out_q[d] <= tx_serial[d / 2];
                end
            end
        end
    end

    assign cdr_in = cdr_q;
    assign serial_out_pair = out_q;
    assign ctrl.drv_en = drv_q;
    assign ctrl.rx_power = rx_q;
    // self-test is active on a low latch bit
    assign ctrl.tx_test = ~{test_q[2], test_q[0]};
    assign ctrl.rx_test = ~{test_q[3], test_q[1]};

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    a_sel_primary: assert property (
        !loop_s && sel_s[0] |=> cdr_in[0] == $past(prim_s[0]))
        else $error("channel a did not take primary input");

    a_sel_secondary: assert property (
        !loop_s && !sel_s[1] |=> cdr_in[1] == $past(sec_s[1]))
        else $error("channel b did not take secondary input");

    a_loop_route: assert property (
        loop_s |=> cdr_in == $past(tx_serial))
        else $error("loopback did not route transmit stream");

    a_loop_drivers: assert property (
        loop_s && drv_q == 4'hf |=> serial_out_pair == 4'hf)
        else $error("enabled driver not forced high in loopback");

    a_loop_ignore: assert property (
        loop_s ##1 loop_s && $changed(prim_s) |=> cdr_in == $past(tx_serial))
        else $error("external input leaked in loopback");

    a_drv_follow: assert property (
        drv_open_s && !devrst_s |=> drv_q == $past(drv_map))
        else $error("driver latch not transparent");

    a_drv_off: assert property (
        !drv_q[3] |=> serial_out_pair[3] == 1'b0)
        else $error("disabled driver still toggling");

    a_drv_hold: assert property (
        !drv_open_s && !devrst_s |=> $stable(drv_q))
        else $error("driver latch moved while closed");

    a_drv_reset: assert property (
        devrst_s |=> drv_q == 4'h0 ##1 serial_out_pair == 4'h0)
        else $error("device reset left a driver on");

    a_rx_follow: assert property (
        rx_open_s && !devrst_s |=> ctrl.rx_power == $past(rx_map))
        else $error("receive latch not transparent");

    a_rx_hold: assert property (
        !rx_open_s && !devrst_s |=> $stable(rx_q))
        else $error("receive latch moved while closed");

    a_rx_reset: assert property (
        devrst_s |=> ctrl.rx_power == 2'h0)
        else $error("device reset left a receiver powered");

    a_test_follow: assert property (
        test_open_s && !bus_s[0] |=> ctrl.tx_test[0])
        else $error("low bit did not start test generation");

    a_test_normal: assert property (
        test_open_s && bus_s[1] |=> !ctrl.rx_test[0])
        else $error("high bit did not select normal reception");

    a_test_hold: assert property (
        !test_open_s && !devrst_s |=> $stable(test_q))
        else $error("self-test latch moved while closed");

    a_test_reset: assert property (
        devrst_s && !test_open_s |=>
            ctrl.tx_test == 2'h0 && ctrl.rx_test == 2'h0)
        else $error("device reset left self-test on");

    a_rst_sample: assert property (
        $fell(sync2_q[0]) |=> drv_q == 4'h0 && rx_q == 2'h0)
        else $error("sampled device reset not applied");

    a_map_fixed: assert property (
        drv_open_s && !devrst_s |=> drv_q[2] == $past(bus_s[2]))
        else $error("driver mapping table broken");

    a_sel_primary_b: assert property (
        !loop_s && sel_s[1] |=> cdr_in[1] == $past(prim_s[1]))
        else $error("channel b did not take primary input");

    a_sel_secondary_a: assert property (
        !loop_s && !sel_s[0] |=> cdr_in[0] == $past(sec_s[0]))
        else $error("channel a did not take secondary input");

    a_loop_each: assert property (
        loop_s |=> (serial_out_pair & $past(drv_q)) == $past(drv_q))
        else $error("enabled driver not held high in loopback");

    a_drv_on_data: assert property (
        !loop_s && drv_q[0] |=> serial_out_pair[0] == $past(tx_serial[0]))
        else $error("enabled driver did not carry its stream");

    a_drv_all_off: assert property (
        drv_q == 4'h0 |=> serial_out_pair == 4'h0)
        else $error("powered down drivers not quiet");

    a_rx_off_b: assert property (
        rx_open_s && !devrst_s && !bus_s[2] |=> !ctrl.rx_power[1])
        else $error("receive channel b powered on a low bit");

    a_test_gen_b: assert property (
        test_open_s && !bus_s[2] |=> ctrl.tx_test[1])
        else $error("low bit did not start test generation on b");

    a_test_cmp_b: assert property (
        test_open_s && !bus_s[3] |=> ctrl.rx_test[1])
        else $error("low bit did not start test comparison on b");

    a_test_norm_tx: assert property (
        test_open_s && bus_s[0] |=> !ctrl.tx_test[0])
        else $error("high bit did not select normal transmission");

    a_test_open_rst: assert property (
        devrst_s && test_open_s |=> test_q == $past(test_map))
        else $error("open self-test latch did not follow the bus");

    a_drv_map_a: assert property (
        drv_open_s && !devrst_s |=> drv_q[0] == $past(bus_s[0]))
        else $error("driver a1 mapping broken");

    a_rx_map_a: assert property (
        rx_open_s && !devrst_s |=> rx_q[0] == $past(bus_s[0]))
        else $error("receive a mapping broken");

    a_rx_map_b: assert property (
        rx_open_s && !devrst_s |=> rx_q[1] == $past(bus_s[2]))
        else $error("receive b mapping broken");

    c_loopback: cover property (loop_s ##1 serial_out_pair == 4'hf);
    c_latch_close: cover property (drv_open_s ##1 !drv_open_s ##1
        drv_q != 4'h0);
    c_selftest: cover property (ctrl.tx_test == 2'h3 &&
        ctrl.rx_test == 2'h3);
    c_input_swap: cover property (sel_s[0] ##1 !sel_s[0]);
    c_dev_reset: cover property (devrst_s ##1 drv_q == 4'h0);

endmodule : spel_top

// [verilog/spel_regs.svh]
// Purpose: constants for the serial port enable latches
// Assumes: one clock, clk_sys at 125 MHz
// Notes: bus bit mapping is fixed in this table
`ifndef SPEL_REGS_SVH
`define SPEL_REGS_SVH

// reset values of the three latches
`define SPEL_DRV_RESET 4'h0
`define SPEL_RX_RESET 2'h0
`define SPEL_TEST_RESET 4'hf

// bus bit feeding each driver enable: a1, a2, b1, b2
`define SPEL_MAP_DRV_A1 2'h0
`define SPEL_MAP_DRV_A2 2'h1
`define SPEL_MAP_DRV_B1 2'h2
`define SPEL_MAP_DRV_B2 2'h3
// bus bit feeding each receive channel power enable
`define SPEL_MAP_RX_A 2'h0
`define SPEL_MAP_RX_B 2'h2
// bus bit feeding each self-test enable
`define SPEL_MAP_TEST_TX_A 2'h0
`define SPEL_MAP_TEST_RX_A 2'h1
`define SPEL_MAP_TEST_TX_B 2'h2
`define SPEL_MAP_TEST_RX_B 2'h3

// synchroniser reset value, device reset held until sampled
`define SPEL_SYNC_RESET 15'h0000

`endif

// [verilog/spel_pkg.sv]
// Purpose: types for the serial port enable latches
// Assumes: two channels, four drivers
// Notes: none
package spel_pkg;

    // state of all three enable latches as seen by the analog side
    typedef struct packed {
        logic [3:0] drv_en;
        logic [1:0] rx_power;
        logic [1:0] tx_test;
        logic [1:0] rx_test;
    } spel_ctrl_type;

    // serial pin groups per channel pair
    typedef struct packed {
        logic [1:0] primary;
        logic [1:0] secondary;
    } spel_serial_in_type;

endpackage : spel_pkg

// [bench/spel_host_model.sv]
// Purpose: host logic driving the static control and serial pins
// Assumes: requests change just after a rising edge
// Notes: pins move on the falling edge, away from the sampling edge
`timescale 1ns/1ps
module spel_host_model (
    input wire logic clk_sys,
    input wire logic [16:0] req,
    output logic [16:0] pins
);
    // device reset pin idles high, everything else low
    initial begin
        pins = 17'h10000;
    end

    always @(negedge clk_sys) begin
        pins <= req;
    end
endmodule : spel_host_model

// [bench/tb_serial_port_enable_latches.sv]
// Purpose: random and corner checks of the enable latches
// Assumes: steady pins for eight cycles cover the sync latency
// Notes: latch contents are tracked by the bench itself
`timescale 1ns/1ps
module tb_serial_port_enable_latches;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [16:0] req = 17'h10000;
    logic [16:0] pins;
    logic [1:0] cdr_in;
    logic [3:0] serial_out_pair;
    spel_pkg::spel_ctrl_type ctrl;
    int err_total = 0;
    int num_checks = 0;
    logic [3:0] drv_m = 4'h0;
    logic [3:0] tst_m = 4'hf;
    logic [1:0] rx_m = 2'h0;

    initial begin
        forever #4 clk_sys = ~clk_sys;
    end

    spel_host_model host (.clk_sys(clk_sys), .req(req), .pins(pins));

    spel_top dut (
        .clk_sys(clk_sys),
        .reset(reset),
        .device_reset_n(pins[16]),
        .shared_enable_bus(pins[15:12]),
        .driver_enable_latch_open(pins[11]),
        .rx_power_latch_open(pins[10]),
        .selftest_latch_open(pins[9]),
        .loopback_enable(pins[8]),
        .input_select_a(pins[7]),
        .input_select_b(pins[6]),
        .serial_in(pins[5:2]),
        .tx_serial(pins[1:0]),
        .cdr_in(cdr_in),
        .serial_out_pair(serial_out_pair),
        .ctrl(ctrl)
    );

    task automatic fail(input string msg);
        err_total++;
        $display("MISMATCH %0t %s", $time, msg);
    endtask : fail

    task automatic conclude();
        if (err_total == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // recovery input per channel: loopback, else selected serial pin
    function automatic logic [1:0] exp_cdr(input logic [16:0] r);
        logic [1:0] e;
        for (int ch = 0; ch < 2; ch++) begin
            e[ch] = r[8] ? r[ch] : (r[7 - ch] ? r[4 + ch] : r[2 + ch]);
        end
        return e;
    endfunction : exp_cdr

    // enabled drivers carry their channel, or one in loopback
    function automatic logic [3:0] exp_out(input logic [16:0] r,
            input logic [3:0] drv);
        return r[8] ? drv : drv & {r[1], r[1], r[0], r[0]};
    endfunction : exp_out

    // hold pins steady, then compare against the tracked latches
    task automatic step(input logic [16:0] r);
        @(posedge clk_sys);
        req <= r;
        repeat (8) @(posedge clk_sys);
        @(negedge clk_sys);
        if (!r[16]) begin
            drv_m = 4'h0;
            rx_m = 2'h0;
            // an open self-test latch keeps following the bus
            tst_m = r[9] ? r[15:12] : 4'hf;
        end else begin
            if (r[11]) drv_m = r[15:12];
            if (r[10]) rx_m = {r[14], r[12]};
            if (r[9]) tst_m = r[15:12];
        end
        num_checks += 5;
        if (ctrl.drv_en !== drv_m) fail("driver enables");
        if (ctrl.rx_power !== rx_m) fail("receive power");
        if (ctrl.tx_test !== ~{tst_m[2], tst_m[0]} ||
                ctrl.rx_test !== ~{tst_m[3], tst_m[1]}) begin
            fail("self-test enables");
        end
        if (cdr_in !== exp_cdr(r)) fail("recovery input");
        if (serial_out_pair !== exp_out(r, drv_m)) begin
            fail("serial drivers");
        end
    endtask : step

    initial begin
        logic [16:0] r;
        repeat (16) @(posedge clk_sys);
        @(negedge clk_sys);
        num_checks++;
        // all latches closed, driver and receive latches cleared, self-test latch set and so off
        if ({ctrl, cdr_in, serial_out_pair} !== 16'h0) begin
            fail("reset state");
        end
        reset = 1'b0;
        void'($urandom(39));
        step({1'b1, 4'hf, 3'b111, 1'b0, 2'b11, 4'h5, 2'h3});
        step({1'b1, 4'h0, 3'b000, 1'b0, 2'b00, 4'h5, 2'h1});
        step({1'b1, 4'h6, 3'b000, 1'b1, 2'b11, 4'hf, 2'h1});
        step({1'b0, 4'hf, 3'b000, 1'b0, 2'b10, 4'ha, 2'h2});
        step({1'b1, 4'ha, 3'b111, 1'b0, 2'b01, 4'h6, 2'h3});
        step({1'b0, 4'h5, 3'b111, 1'b1, 2'b01, 4'h6, 2'h3});
        step({1'b1, 4'h3, 3'b010, 1'b0, 2'b10, 4'h9, 2'h2});
        step({1'b1, 4'h9, 3'b000, 1'b0, 2'b01, 4'h9, 2'h3});
        for (int i = 0; i < 60; i++) begin
            r = 17'($urandom());
            // device reset now and then, not most of the time
            r[16] = ($urandom() % 8) != 0;
            step(r);
        end
        conclude();
    end
endmodule : tb_serial_port_enable_latches
